// File: rtl/led_fault_map.svh
// Purpose: register indices, address index bits, fields and reset values of the fault/current bank
// Assumes: 32-bit AHB-Lite words, one register per aligned word, byte address = 4 * index
// Notes: definitions only
`ifndef LED_FAULT_MAP_SVH
`define LED_FAULT_MAP_SVH

// register indices
`define IDX_OPEN_LOW 12'h07B
`define IDX_OPEN_HIGH 12'h07C
`define IDX_SHORT_LOW 12'h07D
`define IDX_SHORT_HIGH 12'h07E
`define IDX_CURRENT_LED_OUTPUT_ZERO 12'h080
`define IDX_IRQ_STATUS 12'h090
`define IDX_IRQ_MASK 12'h091

// word index taken from the byte address
`define ADDR_INDEX_MSB 13
`define ADDR_INDEX_LSB 2
`define ADDR_INDEX_WIDTH 12

// field layout
`define LOW_GROUP_WIDTH 8
`define HIGH_GROUP_WIDTH 4
`define HIGH_GROUP_BASE 8
`define CURRENT_WIDTH 6
`define SHORT_STATUS_BASE 12
`define STATUS_WIDTH 24

// reset values
`define FLAGS_RESET 12'h000
`define CURRENT_RESET 6'h3F
`define STATUS_RESET 24'h00_0000
`define MASK_RESET 24'h00_0000
`define RDATA_RESET 32'h0000_0000

`endif

// File: rtl/led_fault_pkg.sv
// Purpose: shared types of the fault flag and current setting bank
// Assumes: nothing beyond SystemVerilog packages
// Notes: numeric constants live in led_fault_map.svh
package led_fault_pkg;

	// bus slave phase
	typedef enum logic [0:0] {
		BUS_IDLE,
		BUS_DATA
	} bus_phase_type;

	// decoded register target
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_OPEN_LOW,
		SEL_OPEN_HIGH,
		SEL_SHORT_LOW,
		SEL_SHORT_HIGH,
		SEL_CURRENT,
		SEL_STATUS,
		SEL_MASK
	} reg_sel_type;

endpackage

// File: rtl/fault_flag_capture.sv
// Purpose: brings asynchronous fault detector levels into the clock domain
// Assumes: detector levels may change at any time relative to clk_i
// Notes: a level counts once the second and third stages agree
`timescale 1ns/10ps
module fault_flag_capture #(
	parameter int WIDTH = 12
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [WIDTH-1:0] level_i,
	output logic [WIDTH-1:0] level_o,
	output logic [WIDTH-1:0] rise_o
);

	// elaboration check on width
	if (WIDTH < 1)
	begin : g_bad_width
		$error("fault_flag_capture needs at least one bit");
	end

	genvar b;
	for (b = 0; b < WIDTH; b++)
	begin : g_bit
		logic stage1_reg;
		logic stage2_reg;
		logic stage3_reg;
		logic level_reg;
		logic rise_reg;

		// three-stage synchroniser; stage1 feeds only stage2
		always_ff @(posedge clk_i or negedge resetn_i)
		begin
			if (!resetn_i)
			begin
				stage1_reg <= 1'b0;
				stage2_reg <= 1'b0;
				stage3_reg <= 1'b0;
			end
			else
			begin
				stage1_reg <= level_i[b];
				stage2_reg <= stage1_reg;
				stage3_reg <= stage2_reg;
			end
		end

		// accept only an agreed level, filters a one-cycle glitch
		always_ff @(posedge clk_i or negedge resetn_i)
		begin
			if (!resetn_i)
			begin
				level_reg <= 1'b0;
				rise_reg <= 1'b0;
			end
			else
			begin
				rise_reg <= 1'b0;
				if (stage2_reg == stage3_reg)
				begin
					level_reg <= stage3_reg;
					rise_reg <= stage3_reg & ~level_reg;
				end
			end
		end

		assign level_o[b] = level_reg;
		assign rise_o[b] = rise_reg;
	end

endmodule // fault_flag_capture

// File: rtl/led_fault_flags_and_current_setting.sv
// Purpose: open/short fault flag registers and output 0 current setting, AHB-Lite slave
// Assumes: detectors drive one level per channel, high while a fault is seen
// Notes: one wait state per transfer so that read data comes from a flip-flop
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "led_fault_map.svh"

module led_fault_flags_and_current_setting
	import led_fault_pkg::*;
#(
	parameter int CHANNELS = 12
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// fault detector levels, asynchronous
	input wire logic [CHANNELS-1:0] open_fault_flag_channel_i,
	input wire logic [CHANNELS-1:0] short_fault_flag_channel_i,
	// current code toward led_output_zero driver
	output logic [`CURRENT_WIDTH-1:0] stored_current_code_led_output_zero_o,
	// level interrupt
	output logic irq_o
);

	// the register layout packs exactly twelve channels
	if (CHANNELS != `LOW_GROUP_WIDTH + `HIGH_GROUP_WIDTH)
	begin : g_bad_channels
		$error("register layout serves exactly twelve channels");
	end

	// status and mask hold one bit per channel and fault kind; the code fits one low group
	if (`STATUS_WIDTH != 2 * CHANNELS || `CURRENT_WIDTH > `LOW_GROUP_WIDTH)
	begin : g_bad_fields
		$error("field layout does not fit the register words");
	end

	// synchronised detector levels and their rising edges
	logic [CHANNELS-1:0] open_level;
	logic [CHANNELS-1:0] open_rise;
	logic [CHANNELS-1:0] short_level;
	logic [CHANNELS-1:0] short_rise;

	// flag registers, bus-visible copies of the detector state
	logic [CHANNELS-1:0] open_flags_reg;
	logic [CHANNELS-1:0] short_flags_reg;

	// bus-writable current code and mask, event status and interrupt level
	logic [`CURRENT_WIDTH-1:0] current_code_reg;
	logic [`STATUS_WIDTH-1:0] irq_status_reg;
	logic [`STATUS_WIDTH-1:0] irq_status_next;
	logic [`STATUS_WIDTH-1:0] irq_mask_reg;
	logic irq_reg;

	// bus slave state
	bus_phase_type phase_reg;
	reg_sel_type sel_reg;
	logic write_reg;
	logic [31:0] hrdata_reg;
	logic hreadyout_reg;
	logic hresp_reg;

	// address decode
	logic accept;
	logic [`ADDR_INDEX_WIDTH-1:0] addr_index;
	reg_sel_type sel_decode;
	logic [31:0] read_word;
	logic do_write;
	logic do_read;
	logic [`STATUS_WIDTH-1:0] event_bits;

	// open-circuit detector capture
	fault_flag_capture #(
		.WIDTH(CHANNELS)
	) u_open_capture (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.level_i(open_fault_flag_channel_i),
		.level_o(open_level),
		.rise_o(open_rise)
	);

	// short-circuit detector capture
	fault_flag_capture #(
		.WIDTH(CHANNELS)
	) u_short_capture (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.level_i(short_fault_flag_channel_i),
		.level_o(short_level),
		.rise_o(short_rise)
	);

	// live copy: a fault that goes away reads 0 again; stickiness lives in the status
	// open flag follows detection
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			open_flags_reg <= `FLAGS_RESET;
		end
		else
		begin
			open_flags_reg <= open_level;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			short_flags_reg <= `FLAGS_RESET;
		end
		else
		begin
			short_flags_reg <= short_level;
		end
	end

	// transfer is taken only when selected, ready and non-idle
	assign accept = hsel_i & hready_i & htrans_i[1];
	assign addr_index = haddr_i[`ADDR_INDEX_MSB:`ADDR_INDEX_LSB];

	// an alias would let a stray address land on a flag or the current code
	// index to register target; upper address bits must be zero
	always_comb
	begin
		sel_decode = SEL_NONE;
		if (haddr_i[31:`ADDR_INDEX_MSB+1] == '0 && haddr_i[1:0] == 2'b00)
		begin
			unique case (addr_index)
				`IDX_OPEN_LOW: sel_decode = SEL_OPEN_LOW;
				`IDX_OPEN_HIGH: sel_decode = SEL_OPEN_HIGH;
				`IDX_SHORT_LOW: sel_decode = SEL_SHORT_LOW;
				`IDX_SHORT_HIGH: sel_decode = SEL_SHORT_HIGH;
				`IDX_CURRENT_LED_OUTPUT_ZERO: sel_decode = SEL_CURRENT;
				`IDX_IRQ_STATUS: sel_decode = SEL_STATUS;
				`IDX_IRQ_MASK: sel_decode = SEL_MASK;
				default: sel_decode = SEL_NONE;
			endcase
		end
	end

	// bus phase: address taken, then one wait cycle, then answer
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			phase_reg <= BUS_IDLE;
			sel_reg <= SEL_NONE;
			write_reg <= 1'b0;
		end
		else
		begin
			unique case (phase_reg)
				BUS_IDLE:
				begin
					if (accept)
					begin
						phase_reg <= BUS_DATA;
						sel_reg <= sel_decode;
						write_reg <= hwrite_i;
					end
				end
				BUS_DATA:
				begin
					phase_reg <= BUS_IDLE;
				end
			endcase
		end
	end

	// ready drops for the wait cycle, back high with the answer
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			hreadyout_reg <= 1'b1;
		end
		else if (phase_reg == BUS_IDLE && accept)
		begin
			hreadyout_reg <= 1'b0;
		end
		else
		begin
			hreadyout_reg <= 1'b1;
		end
	end

	// data phase completes at the end of the wait cycle
	assign do_write = (phase_reg == BUS_DATA) & write_reg;
	assign do_read = (phase_reg == BUS_DATA) & ~write_reg;

	// read mux; reserved bits and unmapped words read zero
	always_comb
	begin
		read_word = '0;
		unique case (sel_reg)
			SEL_OPEN_LOW:
				read_word[`LOW_GROUP_WIDTH-1:0] = open_flags_reg[`LOW_GROUP_WIDTH-1:0];
			SEL_OPEN_HIGH:
				read_word[`HIGH_GROUP_WIDTH-1:0] =
					open_flags_reg[CHANNELS-1:`HIGH_GROUP_BASE];
			SEL_SHORT_LOW:
				read_word[`LOW_GROUP_WIDTH-1:0] = short_flags_reg[`LOW_GROUP_WIDTH-1:0];
			SEL_SHORT_HIGH:
				read_word[`HIGH_GROUP_WIDTH-1:0] =
					short_flags_reg[CHANNELS-1:`HIGH_GROUP_BASE];
			SEL_CURRENT:
				read_word[`CURRENT_WIDTH-1:0] = current_code_reg;
			// interrupt status and mask, one bit per channel and fault kind
			SEL_STATUS:
				read_word[`STATUS_WIDTH-1:0] = irq_status_reg;
			SEL_MASK:
				read_word[`STATUS_WIDTH-1:0] = irq_mask_reg;
			SEL_NONE:
				read_word = '0;
		endcase
	end

	// read data registered so the output comes from a flop
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			hrdata_reg <= `RDATA_RESET;
		end
		else if (do_read)
		begin
			hrdata_reg <= read_word;
		end
	end

	// current code write, low six bits only
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			current_code_reg <= `CURRENT_RESET;
		end
		else if (do_write && sel_reg == SEL_CURRENT)
		begin
			current_code_reg <= hwdata_i[`CURRENT_WIDTH-1:0];
		end
	end

	// interrupt mask, same layout as status
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			irq_mask_reg <= `MASK_RESET;
		end
		else if (do_write && sel_reg == SEL_MASK)
		begin
			irq_mask_reg <= hwdata_i[`STATUS_WIDTH-1:0];
		end
	end

	// a new fault on any channel is an event: open low half, short high half
	assign event_bits = {short_rise, open_rise};

	// status clears on read; an event in the same cycle survives the clear
	always_comb
	begin
		irq_status_next = irq_status_reg;
		if (do_read && sel_reg == SEL_STATUS)
		begin
			irq_status_next = '0;
		end
		irq_status_next = irq_status_next | event_bits;
	end

	// sticky event status
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			irq_status_reg <= `STATUS_RESET;
		end
		else
		begin
			irq_status_reg <= irq_status_next;
		end
	end

	// interrupt level from the next status, so it drops with the clearing read
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			irq_reg <= 1'b0;
		end
		else
		begin
			irq_reg <= |(irq_status_next & irq_mask_reg);
		end
	end

	// response register; no error case exists, so it always answers okay
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			hresp_reg <= 1'b0;
		end
		else
		begin
			hresp_reg <= 1'b0;
		end
	end

	// outputs, all straight from flops; response is always OKAY
	assign hrdata_o = hrdata_reg;
	assign hreadyout_o = hreadyout_reg;
	assign hresp_o = hresp_reg;
	assign stored_current_code_led_output_zero_o = current_code_reg;
	assign irq_o = irq_reg;

endmodule // led_fault_flags_and_current_setting

// File: testbench/led_fault_monitor.sv
// Purpose: bus timing and output checks of the fault flag bank
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to the top module at the foot of this file
`timescale 1ns/10ps
`include "led_fault_map.svh"
module led_fault_monitor (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic hsel_i,
	input wire logic [1:0] htrans_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic [`CURRENT_WIDTH-1:0] stored_current_code_led_output_zero_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// a transfer is accepted only while the slave is idle
	logic taken;
	assign taken = hsel_i && hready_i && htrans_i[1] && hreadyout_o;

	resp_okay_a: assert property (hresp_o == 1'b0)
		else $error("slave answered other than okay");
	one_wait_a: assert property (taken |=> !hreadyout_o ##1 hreadyout_o)
		else $error("transfer without exactly one wait state");
	ready_low_once_a: assert property (!hreadyout_o |=> hreadyout_o)
		else $error("wait state longer than one cycle");
	rdata_hold_a: assert property (hreadyout_o |=> $stable(hrdata_o))
		else $error("read data moved outside a read");
	upper_zero_a: assert property (hrdata_o[31:`STATUS_WIDTH] == 8'h00)
		else $error("read data upper bits not zero");
	// the code may only move at the edge ending a write data phase
	current_write_only_a: assert property ($changed(stored_current_code_led_output_zero_o)
		|-> !$past(hreadyout_o))
		else $error("current code changed without a transfer");
	irq_drop_a: assert property ($fell(irq_o)
		|-> (!$past(hreadyout_o) || !$past(hreadyout_o, 2)))
		else $error("interrupt dropped without a transfer");
	reset_state_a: assert property ($rose(resetn_i) |-> stored_current_code_led_output_zero_o == 6'h3F
		&& hreadyout_o && hrdata_o == 32'h0000_0000 && !irq_o)
		else $error("outputs not at reset values");
endmodule // led_fault_monitor

bind led_fault_flags_and_current_setting led_fault_monitor led_fault_monitor_i (
	.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
	.hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
	.stored_current_code_led_output_zero_o(stored_current_code_led_output_zero_o), .irq_o(irq_o));

// File: testbench/tb_led_fault_flags_and_current_setting.sv
// Purpose: self-checking bench of the fault flag and current setting bank
// Assumes: single AHB-Lite master, hready tied back from hreadyout
// Notes: flag inputs get eight cycles to cross the synchroniser
`timescale 1ns/10ps
`include "led_fault_map.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module tb_led_fault_flags_and_current_setting;
	logic clk_i = 1'b0, resetn_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
	logic [1:0] htrans_i = 2'h0;
	logic [31:0] haddr_i = 32'h0000_0000, hwdata_i = 32'h0000_0000, hrdata_o, rd;
	logic hreadyout_o, hresp_o, irq_o;
	logic [11:0] open_i = 12'h000, short_i = 12'h000, o;
	logic [5:0] code_o;
	int miscompares = 0, samples_checked = 0, cycles = 0;

	// 125 MHz clock
	always #4 clk_i = ~clk_i;

	led_fault_flags_and_current_setting led_fault_flags_and_current_setting_i (
		.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
		.hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o), .open_fault_flag_channel_i(open_i),
		.short_fault_flag_channel_i(short_i), .stored_current_code_led_output_zero_o(code_o),
		.irq_o(irq_o));

	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// a hang ends the run with a failure
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miscompares++;
			results();
		end
	end

	// single word transfer; the wait loops never assume a latency
	task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] wd);
		@(posedge clk_i);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		hwrite_i <= w;
		haddr_i <= {18'h0_0000, idx, 2'h0};
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		rd = hrdata_o;
	endtask

	task automatic rchk(input logic [11:0] idx, input logic [31:0] e, input string n);
		xfer(1'b0, idx, 32'h0000_0000);
		`CHK(n, e, rd)
	endtask

	task automatic t_reset();
		`CHK("code", 6'h3F, code_o)
		rchk(`IDX_OPEN_LOW, 32'h0000_0000, "ol");
		rchk(`IDX_OPEN_HIGH, 32'h0000_0000, "oh");
		rchk(`IDX_SHORT_LOW, 32'h0000_0000, "sl");
		rchk(`IDX_SHORT_HIGH, 32'h0000_0000, "sh");
		rchk(`IDX_CURRENT_LED_OUTPUT_ZERO, 32'h0000_003F, "cur");
	endtask

	// walking one on open, its inverse on short, then all open
	task automatic t_flags();
		for (int k = 0; k < 13; k++)
		begin
			o = (k < 12) ? (12'h001 << k) : 12'hFFF;
			@(posedge clk_i);
			open_i <= o;
			short_i <= ~o;
			repeat (8) @(posedge clk_i);
			rchk(`IDX_OPEN_LOW, {24'h00_0000, o[7:0]}, "ol");
			rchk(`IDX_OPEN_HIGH, {28'h000_0000, o[11:8]}, "oh");
			rchk(`IDX_SHORT_LOW, {24'h00_0000, ~o[7:0]}, "sl");
			rchk(`IDX_SHORT_HIGH, {28'h000_0000, ~o[11:8]}, "sh");
		end
		@(posedge clk_i);
		open_i <= 12'h000;
		short_i <= 12'h000;
		repeat (8) @(posedge clk_i);
	endtask

	// writes to flags, reserved bits and an unmapped word change nothing
	task automatic t_writes();
		xfer(1'b1, `IDX_CURRENT_LED_OUTPUT_ZERO, 32'hFFFF_FFEA);
		`CHK("code", 6'h2A, code_o)
		for (int i = 0; i < 4; i++)
			xfer(1'b1, `IDX_OPEN_LOW + i[11:0], 32'hFFFF_FFFF);
		xfer(1'b1, 12'h0A0, 32'hFFFF_FFFF);
		rchk(`IDX_OPEN_HIGH, 32'h0000_0000, "oh");
		rchk(`IDX_SHORT_LOW, 32'h0000_0000, "sl");
		rchk(12'h0A0, 32'h0000_0000, "unmapped");
		rchk(`IDX_CURRENT_LED_OUTPUT_ZERO, 32'h0000_002A, "cur");
	endtask

	// sticky status, masking and clear on read
	task automatic t_irq();
		`CHK("irq", 1'b0, irq_o)
		rchk(`IDX_IRQ_STATUS, 32'h00FF_FFFF, "stat");
		rchk(`IDX_IRQ_STATUS, 32'h0000_0000, "stat");
		xfer(1'b1, `IDX_IRQ_MASK, 32'h0000_1008);
		rchk(`IDX_IRQ_MASK, 32'h0000_1008, "mask");
		@(posedge clk_i);
		open_i <= 12'h020;
		repeat (8) @(posedge clk_i);
		`CHK("irq", 1'b0, irq_o)
		open_i <= 12'h028;
		repeat (8) @(posedge clk_i);
		`CHK("irq", 1'b1, irq_o)
		rchk(`IDX_IRQ_STATUS, 32'h0000_0028, "stat");
		@(posedge clk_i);
		`CHK("irq", 1'b0, irq_o)
		short_i <= 12'h001;
		repeat (8) @(posedge clk_i);
		`CHK("irq", 1'b1, irq_o)
		rchk(`IDX_IRQ_STATUS, 32'h0000_1000, "stat");
	endtask

	// reset in mid-run restores the code; faults still present are seen again
	task automatic t_midreset();
		@(posedge clk_i);
		resetn_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		`CHK("code", 6'h3F, code_o)
		resetn_i <= 1'b1;
		rchk(`IDX_CURRENT_LED_OUTPUT_ZERO, 32'h0000_003F, "cur");
		repeat (8) @(posedge clk_i);
		rchk(`IDX_OPEN_LOW, 32'h0000_0028, "ol");
		rchk(`IDX_SHORT_LOW, 32'h0000_0001, "sl");
	endtask

	// reset for five cycles, then the scenarios
	initial
	begin
		repeat (5) @(posedge clk_i);
		resetn_i <= 1'b1;
		t_reset();
		t_flags();
		t_writes();
		t_irq();
		t_midreset();
		results();
	end
endmodule // tb_led_fault_flags_and_current_setting
